// file: core/mlmc_core.sv
// Maximum-address and block-size command interpreter
`timescale 1ns/100ps
module mlmc_core #(
	parameter logic [7:0] READ_NATIVE_CODE = 8'h27,
	parameter bit EXT_SUPPORTED = 1'b1
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// Register port
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	// Neighbouring device state
	input wire logic [47:0] i_native_max,
	input wire logic i_hpa28_set,
	input wire logic i_locked,
	input wire logic i_freeze_done,
	input wire logic i_addr_offset_mode,
	input wire logic i_nv_valid,
	input wire logic [47:0] i_nv_max,
	// Media access check
	input wire logic i_access_req,
	input wire logic [47:0] i_access_lba,
	output logic o_access_abort,
	// Results
	output logic [47:0] o_max_lba,
	output logic o_nv_store,
	output logic o_mult_en,
	output logic [4:0] o_mult_size,
	output logic o_irq
);
	localparam int IRQ_W_L = mlmc_pkg::IRQ_W;
	mlmc_pkg::mlmc_state_t state_q;
	mlmc_pkg::mlmc_tf_t tf_q;
	logic hob_q, busy_q, abt_q, rnm_q, rnm_prev_q, frozen_q, nv_done_q, lo_upd_q;
	logic [7:0] cmd_q, status, err, mult_req;
	logic [47:0] max_q, req_lba;
	logic [2:0] idx_q, id_sel_q;
	logic [15:0] id_rdata, id_wdata;
	logic [IRQ_W_L-1:0] irq_stat_q, irq_mask_q;
	logic nv_req, abort_max, mult_ok, cmd_wr, id_we, ev_done, ev_abort;

	assign cmd_wr = i_wr && i_addr == mlmc_pkg::OFS_CMD;
	// Address bytes: current pairs low, previous pairs high
	assign req_lba = {tf_q.cyl_hi.prev, tf_q.cyl_lo.prev, tf_q.sec_num.prev,
		tf_q.cyl_hi.cur, tf_q.cyl_lo.cur, tf_q.sec_num.cur};
	assign nv_req = tf_q.sec_cnt.cur[mlmc_pkg::RETAIN_BIT];
	assign mult_req = tf_q.sec_cnt.cur;

	// All abort causes for the extended set
	always_comb begin
		abort_max = !EXT_SUPPORTED || req_lba > i_native_max || i_hpa28_set || i_locked
			|| frozen_q;
		if (!rnm_prev_q) begin
			abort_max = 1'b1;
		end
		if (nv_req && (i_addr_offset_mode || nv_done_q)) begin
			abort_max = 1'b1;
		end
	end

	// Sizes 0,1,2,4,8,16 only
	assign mult_ok = mult_req <= mlmc_pkg::MULT_MAX && (mult_req & (mult_req - 8'h01)) == 8'h00;

	// Command sequencing
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= mlmc_pkg::ST_INIT;
		end else begin
			unique case (state_q)
				mlmc_pkg::ST_INIT: begin
					state_q <= mlmc_pkg::ST_IDW;
				end
				mlmc_pkg::ST_IDLE: begin
					if (cmd_wr && (i_wdata[7:0] == mlmc_pkg::CMD_SET_MAX_EXT
						|| i_wdata[7:0] == mlmc_pkg::CMD_SET_MULT)) begin
						state_q <= mlmc_pkg::ST_EXEC;
					end
				end
				mlmc_pkg::ST_EXEC: begin
					if (cmd_q == mlmc_pkg::CMD_SET_MAX_EXT && !abort_max) begin
						state_q <= mlmc_pkg::ST_IDW;
					end else begin
						state_q <= mlmc_pkg::ST_IDLE;
					end
				end
				mlmc_pkg::ST_IDW: begin
					if (idx_q == mlmc_pkg::ID_LAST) begin
						state_q <= mlmc_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	// Identify word walk index
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			idx_q <= mlmc_pkg::ID_W60;
		end else if (state_q == mlmc_pkg::ST_IDW) begin
			idx_q <= (idx_q == mlmc_pkg::ID_LAST) ? mlmc_pkg::ID_W60 : idx_q + 3'h1;
		end
	end

	// Words 60..61 only when the maximum fits 28 bits
	assign id_we = state_q == mlmc_pkg::ST_IDW && (idx_q >= mlmc_pkg::ID_W100 || lo_upd_q);
	always_comb begin
		unique case (idx_q)
			3'h0: id_wdata = max_q[15:0];
			3'h1: id_wdata = {4'h0, max_q[27:16]};
			3'h2: id_wdata = max_q[15:0];
			3'h3: id_wdata = max_q[31:16];
			3'h4: id_wdata = max_q[47:32];
			default: id_wdata = 16'h0000;
		endcase
	end

	mlmc_id_mem #(
		.DEPTH(8),
		.WIDTH(16)
	) u_id_mem (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_we(id_we),
		.i_waddr(idx_q),
		.i_wdata(id_wdata),
		.i_raddr(id_sel_q),
		.o_rdata(id_rdata)
	);

	// Maximum address; retained copy taken after reset release
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			max_q <= '0;
			lo_upd_q <= 1'b0;
		end else if (state_q == mlmc_pkg::ST_INIT) begin
			max_q <= i_nv_valid ? i_nv_max : i_native_max;
			lo_upd_q <= (i_nv_valid ? i_nv_max : i_native_max) <= mlmc_pkg::LBA28_LIMIT;
		end else if (state_q == mlmc_pkg::ST_EXEC && cmd_q == mlmc_pkg::CMD_SET_MAX_EXT
			&& !abort_max) begin
			max_q <= req_lba;
			lo_upd_q <= req_lba <= mlmc_pkg::LBA28_LIMIT;
		end
	end

	// Nonvolatile bookkeeping and store request
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			nv_done_q <= 1'b0;
			o_nv_store <= 1'b0;
		end else begin
			o_nv_store <= 1'b0;
			if (state_q == mlmc_pkg::ST_EXEC && cmd_q == mlmc_pkg::CMD_SET_MAX_EXT
				&& !abort_max && nv_req) begin
				nv_done_q <= 1'b1;
				o_nv_store <= 1'b1;
			end
		end
	end

	// Freeze is sticky until reset
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			frozen_q <= 1'b0;
		end else if (i_freeze_done) begin
			frozen_q <= 1'b1;
		end
	end

	// Command register, busy, abort, preceding-command flag
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cmd_q <= 8'h00;
			busy_q <= 1'b0;
			abt_q <= 1'b0;
			rnm_q <= 1'b0;
			rnm_prev_q <= 1'b0;
		end else begin
			if (cmd_wr && state_q == mlmc_pkg::ST_IDLE) begin
				cmd_q <= i_wdata[7:0];
				rnm_q <= i_wdata[7:0] == READ_NATIVE_CODE;
				rnm_prev_q <= rnm_q;
				if (i_wdata[7:0] == mlmc_pkg::CMD_SET_MAX_EXT
					|| i_wdata[7:0] == mlmc_pkg::CMD_SET_MULT) begin
					busy_q <= 1'b1;
					abt_q <= 1'b0;
				end
			end
			if (state_q == mlmc_pkg::ST_EXEC) begin
				if (cmd_q == mlmc_pkg::CMD_SET_MAX_EXT) begin
					abt_q <= abort_max;
					busy_q <= !abort_max;
				end else begin
					abt_q <= !mult_ok;
					busy_q <= 1'b0;
				end
			end
			if (state_q == mlmc_pkg::ST_IDW && idx_q == mlmc_pkg::ID_LAST) begin
				busy_q <= 1'b0;
			end
		end
	end

	// Block size for multi-sector transfers
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_mult_en <= 1'b0;
			o_mult_size <= mlmc_pkg::MULT_SIZE_RST;
		end else if (state_q == mlmc_pkg::ST_EXEC && cmd_q == mlmc_pkg::CMD_SET_MULT) begin
			o_mult_en <= mult_ok && mult_req != 8'h00;
			o_mult_size <= mult_ok ? mult_req[4:0] : mlmc_pkg::MULT_SIZE_RST;
		end
	end

	// Task-file byte pairs: a write shifts current into previous
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tf_q <= '0;
			hob_q <= 1'b0;
		end else begin
			if (i_wr && state_q == mlmc_pkg::ST_IDLE) begin
				unique case (i_addr)
					mlmc_pkg::OFS_SEC_CNT: tf_q.sec_cnt <= {tf_q.sec_cnt.cur, i_wdata[7:0]};
					mlmc_pkg::OFS_SEC_NUM: tf_q.sec_num <= {tf_q.sec_num.cur, i_wdata[7:0]};
					mlmc_pkg::OFS_CYL_LO: tf_q.cyl_lo <= {tf_q.cyl_lo.cur, i_wdata[7:0]};
					mlmc_pkg::OFS_CYL_HI: tf_q.cyl_hi <= {tf_q.cyl_hi.cur, i_wdata[7:0]};
					default: ;
				endcase
			end
			if (i_wr && i_addr == mlmc_pkg::OFS_DEV_CTL) begin
				hob_q <= i_wdata[mlmc_pkg::HOB_BIT];
			end
			// Return the maximum now in force, same byte order
			if (state_q == mlmc_pkg::ST_EXEC && cmd_q == mlmc_pkg::CMD_SET_MAX_EXT) begin
				tf_q.sec_num <= {max_q[31:24], max_q[7:0]};
				tf_q.cyl_lo <= {max_q[39:32], max_q[15:8]};
				tf_q.cyl_hi <= {max_q[47:40], max_q[23:16]};
				if (!abort_max) begin
					tf_q.sec_num <= {req_lba[31:24], req_lba[7:0]};
					tf_q.cyl_lo <= {req_lba[39:32], req_lba[15:8]};
					tf_q.cyl_hi <= {req_lba[47:40], req_lba[23:16]};
				end
			end
		end
	end

	// Access check against the maximum
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_access_abort <= 1'b0;
		end else begin
			o_access_abort <= i_access_req && i_access_lba > max_q;
		end
	end

	// Interrupt status: set wins over the read clear
	assign ev_done = (state_q == mlmc_pkg::ST_EXEC && !(cmd_q == mlmc_pkg::CMD_SET_MAX_EXT
		&& !abort_max)) || (state_q == mlmc_pkg::ST_IDW && idx_q == mlmc_pkg::ID_LAST
		&& busy_q);
	assign ev_abort = state_q == mlmc_pkg::ST_EXEC && (cmd_q == mlmc_pkg::CMD_SET_MAX_EXT
		? abort_max : !mult_ok);
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_stat_q <= '0;
		end else begin
			if (i_rd && i_addr == mlmc_pkg::OFS_IRQ_STAT) begin
				irq_stat_q <= '0;
			end
			if (ev_done) begin
				irq_stat_q[mlmc_pkg::IRQ_DONE_BIT] <= 1'b1;
			end
			if (ev_abort) begin
				irq_stat_q[mlmc_pkg::IRQ_ABORT_BIT] <= 1'b1;
			end
			if (o_access_abort) begin
				irq_stat_q[mlmc_pkg::IRQ_REJECT_BIT] <= 1'b1;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_mask_q <= mlmc_pkg::IRQ_MASK_RST;
			id_sel_q <= 3'h0;
		end else if (i_wr) begin
			if (i_addr == mlmc_pkg::OFS_IRQ_MASK) begin
				irq_mask_q <= i_wdata[IRQ_W_L-1:0];
			end
			if (i_addr == mlmc_pkg::OFS_ID_SEL) begin
				id_sel_q <= i_wdata[2:0];
			end
		end
	end

	assign o_irq = |(irq_stat_q & irq_mask_q);
	assign o_max_lba = max_q;

	// Only abort is ever reported
	always_comb begin
		status = 8'h00;
		status[mlmc_pkg::ST_BSY_BIT] = busy_q;
		status[mlmc_pkg::ST_RDY_BIT] = !busy_q;
		status[mlmc_pkg::ST_ERR_BIT] = abt_q && !busy_q;
		err = 8'h00;
		err[mlmc_pkg::ER_ABT_BIT] = abt_q && !busy_q;
	end

	// Read data one cycle after the strobe; status captured at the strobe
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= 32'h0000_0000;
		end else begin
			o_rdata <= 32'h0000_0000;
			if (i_rd) begin
				unique case (i_addr)
					mlmc_pkg::OFS_SEC_CNT: o_rdata[7:0] <= hob_q ? tf_q.sec_cnt.prev : tf_q.sec_cnt.cur;
					mlmc_pkg::OFS_SEC_NUM: o_rdata[7:0] <= hob_q ? tf_q.sec_num.prev : tf_q.sec_num.cur;
					mlmc_pkg::OFS_CYL_LO: o_rdata[7:0] <= hob_q ? tf_q.cyl_lo.prev : tf_q.cyl_lo.cur;
					mlmc_pkg::OFS_CYL_HI: o_rdata[7:0] <= hob_q ? tf_q.cyl_hi.prev : tf_q.cyl_hi.cur;
					mlmc_pkg::OFS_DEV_CTL: o_rdata[mlmc_pkg::HOB_BIT] <= hob_q;
					mlmc_pkg::OFS_CMD: o_rdata[7:0] <= status;
					mlmc_pkg::OFS_ERR: o_rdata[7:0] <= err;
					mlmc_pkg::OFS_IRQ_STAT: o_rdata[IRQ_W_L-1:0] <= irq_stat_q;
					mlmc_pkg::OFS_IRQ_MASK: o_rdata[IRQ_W_L-1:0] <= irq_mask_q;
					mlmc_pkg::OFS_MULT: o_rdata[5:0] <= {o_mult_en, o_mult_size};
					mlmc_pkg::OFS_MAX_LO: o_rdata <= max_q[31:0];
					mlmc_pkg::OFS_MAX_HI: o_rdata[15:0] <= max_q[47:32];
					mlmc_pkg::OFS_ID_SEL: o_rdata[2:0] <= id_sel_q;
					mlmc_pkg::OFS_ID_DATA: o_rdata[15:0] <= id_rdata;
					default: ;
				endcase
			end
		end
	end

endmodule

// file: include/mlmc_pkg.sv
// Package for the maximum-address and block-size command interpreter
package mlmc_pkg;
	// Command codes
	localparam logic [7:0] CMD_SET_MAX_EXT = 8'h37;
	localparam logic [7:0] CMD_SET_MULT = 8'hC6;

	// Register byte offsets
	localparam logic [7:0] OFS_SEC_CNT = 8'h04;
	localparam logic [7:0] OFS_SEC_NUM = 8'h08;
	localparam logic [7:0] OFS_CYL_LO = 8'h0C;
	localparam logic [7:0] OFS_CYL_HI = 8'h10;
	localparam logic [7:0] OFS_DEV_CTL = 8'h14;
	localparam logic [7:0] OFS_CMD = 8'h18;
	localparam logic [7:0] OFS_ERR = 8'h1C;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
	localparam logic [7:0] OFS_MULT = 8'h28;
	localparam logic [7:0] OFS_MAX_LO = 8'h2C;
	localparam logic [7:0] OFS_MAX_HI = 8'h30;
	localparam logic [7:0] OFS_ID_SEL = 8'h34;
	localparam logic [7:0] OFS_ID_DATA = 8'h38;

	// Field positions and the interrupt field width
	localparam int HOB_BIT = 7;
	localparam int RETAIN_BIT = 0;
	localparam int ST_BSY_BIT = 7;
	localparam int ST_RDY_BIT = 6;
	localparam int ST_ERR_BIT = 0;
	localparam int ER_ABT_BIT = 2;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_ABORT_BIT = 1;
	localparam int IRQ_REJECT_BIT = 2;
	localparam int IRQ_W = 3;

	// Limits and reset values
	localparam logic [47:0] LBA28_LIMIT = 48'h0000_0FFF_FFFF;
	localparam logic [7:0] MULT_MAX = 8'h10;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
	localparam logic [4:0] MULT_SIZE_RST = 5'h00;

	// Identify entries: words 60,61,100,101,102,103
	localparam int ID_ENTRIES = 6;
	localparam logic [2:0] ID_W60 = 3'h0;
	localparam logic [2:0] ID_W61 = 3'h1;
	localparam logic [2:0] ID_W100 = 3'h2;
	localparam logic [2:0] ID_LAST = 3'h5;

	typedef struct packed {
		logic [7:0] prev;
		logic [7:0] cur;
	} mlmc_pair_t;

	typedef struct packed {
		mlmc_pair_t cyl_hi;
		mlmc_pair_t cyl_lo;
		mlmc_pair_t sec_num;
		mlmc_pair_t sec_cnt;
	} mlmc_tf_t;

	typedef enum logic [3:0] {
		ST_INIT = 4'b0001,
		ST_IDLE = 4'b0010,
		ST_EXEC = 4'b0100,
		ST_IDW = 4'b1000
	} mlmc_state_t;
endpackage

// file: core/mlmc_id_mem.sv
// Small identify-word store with a registered read port
`timescale 1ns/100ps
module mlmc_id_mem #(
	parameter int DEPTH = 8,
	parameter int WIDTH = 16
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// Write port
	input wire logic i_we,
	input wire logic [$clog2(DEPTH)-1:0] i_waddr,
	input wire logic [WIDTH-1:0] i_wdata,
	// Read port
	input wire logic [$clog2(DEPTH)-1:0] i_raddr,
	output logic [WIDTH-1:0] o_rdata
);
	logic [WIDTH-1:0] mem_q [DEPTH];

	for (genvar g = 0; g < DEPTH; g++) begin : g_word
		always_ff @(posedge i_core_clk or negedge i_rst_n) begin
			if (!i_rst_n) begin
				mem_q[g] <= '0;
			end else if (i_we && i_waddr == g) begin
				mem_q[g] <= i_wdata;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= '0;
		end else begin
			o_rdata <= mem_q[i_raddr];
		end
	end
endmodule

// file: tb/mlmc_core_monitor.sv
// Port-level checks for the command interpreter
`timescale 1ns/100ps
module mlmc_core_monitor (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// Register port
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] o_rdata,
	// Device state and media check
	input wire logic i_freeze_done,
	input wire logic i_addr_offset_mode,
	input wire logic i_access_req,
	input wire logic [47:0] i_access_lba,
	input wire logic o_access_abort,
	// Results
	input wire logic [47:0] o_max_lba,
	input wire logic o_nv_store,
	input wire logic o_mult_en,
	input wire logic [4:0] o_mult_size
);
	logic wr_cmd;
	logic nv_seen_q;
	logic frozen_q;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	assign wr_cmd = i_wr && (i_addr == mlmc_pkg::OFS_CMD);
	// Sticky markers, cleared only by reset like the state they track
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			nv_seen_q <= 1'b0;
			frozen_q <= 1'b0;
		end else begin
			if (o_nv_store)
				nv_seen_q <= 1'b1;
			if (i_freeze_done)
				frozen_q <= 1'b1;
		end
	end
	a_access_reject: assert property (o_access_abort ==
		$past(i_access_req && (i_access_lba > o_max_lba)))
		else $error("access abort does not match the limit");
	a_mult_valid: assert property (o_mult_size inside {5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10})
		else $error("illegal block size");
	a_mult_enable: assert property (o_mult_en == (o_mult_size != 5'h00))
		else $error("enable and block size disagree");
	a_mult_cause: assert property ($changed({o_mult_en, o_mult_size}) |->
		$past(wr_cmd && i_wdata[7:0] == mlmc_pkg::CMD_SET_MULT, 2) ||
		$past(wr_cmd && i_wdata[7:0] == mlmc_pkg::CMD_SET_MULT, 3))
		else $error("block size changed without a command");
	a_nv_cause: assert property (o_nv_store |-> !i_addr_offset_mode &&
		($past(wr_cmd && i_wdata[7:0] == mlmc_pkg::CMD_SET_MAX_EXT, 2) ||
		$past(wr_cmd && i_wdata[7:0] == mlmc_pkg::CMD_SET_MAX_EXT, 3)))
		else $error("nonvolatile store without a valid command");
	a_nv_once: assert property (o_nv_store |-> !nv_seen_q)
		else $error("second nonvolatile store");
	a_frozen_hold: assert property (frozen_q |=> $stable(o_max_lba) && !o_nv_store)
		else $error("maximum changed while frozen");
	a_rdata_slot: assert property (!$past(i_rd) |-> o_rdata == 32'h0000_0000)
		else $error("read data outside its slot");
endmodule

bind mlmc_core mlmc_core_monitor u_mon (.i_core_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr,
	.i_rd, .o_rdata, .i_freeze_done, .i_addr_offset_mode, .i_access_req, .i_access_lba,
	.o_access_abort, .o_max_lba, .o_nv_store, .o_mult_en, .o_mult_size);

// file: tb/mlmc_host.sv
// Host controller model driving the register port
`timescale 1ns/100ps
module mlmc_host (
	// Clock
	input wire logic i_core_clk,
	// Register port toward the device
	output logic [7:0] o_addr,
	output logic [31:0] o_wdata,
	output logic o_wr,
	output logic o_rd,
	input wire logic [31:0] i_rdata
);
	initial begin
		o_addr = 8'h00;
		o_wdata = 32'h0000_0000;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_core_clk);
		o_wr <= 1'b0;
		// Released data must not look like a stale valid value
		o_wdata <= ~d;
		@(posedge i_core_clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_core_clk);
		o_rd <= 1'b0;
		#1 d = i_rdata;
		@(posedge i_core_clk);
	endtask
	// High byte first: a write shifts current into previous
	task automatic set_max(input logic [47:0] lba, input logic nv, input logic pre);
		wr(mlmc_pkg::OFS_SEC_CNT, {31'h0000_0000, nv});
		wr(mlmc_pkg::OFS_SEC_NUM, {24'h00_0000, lba[31:24]});
		wr(mlmc_pkg::OFS_SEC_NUM, {24'h00_0000, lba[7:0]});
		wr(mlmc_pkg::OFS_CYL_LO, {24'h00_0000, lba[39:32]});
		wr(mlmc_pkg::OFS_CYL_LO, {24'h00_0000, lba[15:8]});
		wr(mlmc_pkg::OFS_CYL_HI, {24'h00_0000, lba[47:40]});
		wr(mlmc_pkg::OFS_CYL_HI, {24'h00_0000, lba[23:16]});
		if (pre)
			wr(mlmc_pkg::OFS_CMD, 32'h0000_0027);
		wr(mlmc_pkg::OFS_CMD, {24'h00_0000, mlmc_pkg::CMD_SET_MAX_EXT});
	endtask
endmodule

// file: tb/testbench.sv
// Self-checking bench for the command interpreter
`timescale 1ns/100ps
module testbench;
	localparam logic [47:0] NATIVE = 48'h0000_2000_0000;
	localparam logic [47:0] BIG = 48'h0000_1234_5678;
	localparam logic [47:0] NV_KEPT = 48'h0000_0000_1000;
	logic i_core_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic wr;
	logic rd;
	logic [31:0] rdata;
	logic hpa28 = 1'b0;
	logic locked = 1'b0;
	logic freeze = 1'b0;
	logic offs = 1'b0;
	logic nv_valid = 1'b0;
	logic nv_store;
	logic [47:0] cur_max = NATIVE;
	logic acc_req = 1'b0;
	logic [47:0] acc_lba = 48'h0000_0000_0000;
	logic acc_abort;
	logic [47:0] max_lba;
	logic mult_en;
	logic [4:0] mult_size;
	logic irq;
	logic [7:0] sz [8] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h03, 8'h10, 8'h11};
	int bad_count = 0;
	int n_compared = 0;
	int nv_cnt = 0;
	always #12.5 i_core_clk = ~i_core_clk;
	// Count nonvolatile store pulses
	always @(posedge i_core_clk) begin
		if (nv_store === 1'b1)
			nv_cnt++;
	end
	mlmc_host u_host (.i_core_clk(i_core_clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr),
		.o_rd(rd), .i_rdata(rdata));
	mlmc_core u_dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_native_max(NATIVE),
		.i_hpa28_set(hpa28), .i_locked(locked), .i_freeze_done(freeze),
		.i_addr_offset_mode(offs), .i_nv_valid(nv_valid), .i_nv_max(NV_KEPT),
		.i_access_req(acc_req), .i_access_lba(acc_lba), .o_access_abort(acc_abort),
		.o_max_lba(max_lba), .o_nv_store(nv_store), .o_mult_en(mult_en), .o_mult_size(mult_size),
		.o_irq(irq));
	task automatic results;
		if (bad_count == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		u_host.rd(a, d);
		chk({16'h0000, d}, {16'h0000, exp});
	endtask
	task automatic wait_idle;
		logic [31:0] d;
		for (int i = 0; i < 20; i++) begin
			u_host.rd(mlmc_pkg::OFS_CMD, d);
			if (d[mlmc_pkg::ST_BSY_BIT] === 1'b0)
				return;
		end
		bad_count++;
		results();
	endtask
	task automatic do_max(input logic [47:0] lba, input logic nv, input logic pre,
		input logic ok);
		logic [47:0] exp;
		exp = ok ? lba : cur_max;
		u_host.set_max(lba, nv, pre);
		wait_idle();
		rchk(mlmc_pkg::OFS_ERR, ok ? 32'h0000_0000 : 32'h0000_0004);
		rchk(mlmc_pkg::OFS_CMD, ok ? 32'h0000_0040 : 32'h0000_0041);
		chk(max_lba, exp);
		cur_max = exp;
	endtask
	task automatic acc(input logic [47:0] lba, input logic exp);
		acc_req <= 1'b1;
		acc_lba <= lba;
		@(posedge i_core_clk);
		acc_req <= 1'b0;
		#1 chk(acc_abort, exp);
		@(posedge i_core_clk);
	endtask
	task automatic idchk(input logic [2:0] s, input logic [15:0] exp);
		u_host.wr(mlmc_pkg::OFS_ID_SEL, {29'h0000_0000, s});
		rchk(mlmc_pkg::OFS_ID_DATA, {16'h0000, exp});
	endtask
	task automatic t_reset;
		chk(max_lba, NATIVE);
		rchk(mlmc_pkg::OFS_MULT, 32'h0000_0000);
		rchk(mlmc_pkg::OFS_IRQ_MASK, 32'h0000_0000);
		u_host.wr(8'hFC, 32'hFFFF_FFFF);
		rchk(8'hFC, 32'h0000_0000);
		rchk(mlmc_pkg::OFS_CMD, 32'h0000_0040);
	endtask
	task automatic t_set_ok;
		do_max(BIG, 1'b0, 1'b1, 1'b1);
		chk(irq, 1'b0);
		u_host.wr(mlmc_pkg::OFS_IRQ_MASK, 32'h0000_0007);
		chk(irq, 1'b1);
		rchk(mlmc_pkg::OFS_IRQ_STAT, 32'h0000_0001);
		chk(irq, 1'b0);
		for (int h = 0; h < 2; h++) begin
			u_host.wr(mlmc_pkg::OFS_DEV_CTL, h ? 32'h0000_0080 : 32'h0000_0000);
			rchk(mlmc_pkg::OFS_SEC_NUM, {24'h00_0000, BIG[h*24 +: 8]});
			rchk(mlmc_pkg::OFS_CYL_LO, {24'h00_0000, BIG[h*24+8 +: 8]});
			rchk(mlmc_pkg::OFS_CYL_HI, {24'h00_0000, BIG[h*24+16 +: 8]});
		end
		rchk(mlmc_pkg::OFS_MAX_LO, BIG[31:0]);
		rchk(mlmc_pkg::OFS_MAX_HI, {16'h0000, BIG[47:32]});
		idchk(3'h0, 16'h0000);
		idchk(3'h3, BIG[31:16]);
		acc(BIG, 1'b0);
		acc(BIG + 48'h0000_0000_0001, 1'b1);
		rchk(mlmc_pkg::OFS_IRQ_STAT, 32'h0000_0004);
	endtask
	task automatic t_aborts;
		for (int k = 0; k < 5; k++) begin
			hpa28 <= (k == 2);
			locked <= (k == 3);
			offs <= (k == 4);
			@(posedge i_core_clk);
			do_max(k == 1 ? NATIVE + 48'h0000_0000_0001 : 48'h0000_0000_4000, k == 4, k != 0,
				1'b0);
		end
		hpa28 <= 1'b0;
		locked <= 1'b0;
		offs <= 1'b0;
		rchk(mlmc_pkg::OFS_IRQ_STAT, 32'h0000_0003);
	endtask
	task automatic t_nv;
		do_max(NV_KEPT, 1'b1, 1'b1, 1'b1);
		do_max(48'h0000_0000_0800, 1'b1, 1'b1, 1'b0);
		do_max(48'h0000_0000_0900, 1'b0, 1'b1, 1'b1);
		chk(nv_cnt, 1);
		idchk(3'h0, 16'h0900);
		idchk(3'h2, 16'h0900);
	endtask
	task automatic t_power;
		i_rst_n <= 1'b0;
		nv_valid <= 1'b1;
		repeat (3) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		repeat (10) @(posedge i_core_clk);
		cur_max = NV_KEPT;
		chk(max_lba, NV_KEPT);
		idchk(3'h0, NV_KEPT[15:0]);
		do_max(48'h0000_0000_2000, 1'b1, 1'b1, 1'b1);
		chk(nv_cnt, 2);
	endtask
	task automatic t_freeze;
		freeze <= 1'b1;
		@(posedge i_core_clk);
		freeze <= 1'b0;
		@(posedge i_core_clk);
		do_max(48'h0000_0000_2000, 1'b0, 1'b1, 1'b0);
	endtask
	task automatic t_mult;
		logic ok;
		for (int k = 0; k < 8; k++) begin
			ok = sz[k] inside {8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10};
			u_host.wr(mlmc_pkg::OFS_SEC_CNT, {24'h00_0000, sz[k]});
			u_host.wr(mlmc_pkg::OFS_CMD, {24'h00_0000, mlmc_pkg::CMD_SET_MULT});
			wait_idle();
			rchk(mlmc_pkg::OFS_ERR, ok ? 32'h0000_0000 : 32'h0000_0004);
			chk(mult_en, ok && sz[k] != 8'h00);
			chk(mult_size, ok ? sz[k][4:0] : 5'h00);
			rchk(mlmc_pkg::OFS_MULT, {26'h000_0000, ok && sz[k] != 8'h00,
				ok ? sz[k][4:0] : 5'h00});
		end
	endtask
	initial begin
		repeat (3) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		repeat (10) @(posedge i_core_clk);
		t_reset();
		t_set_ok();
		t_aborts();
		t_mult();
		t_nv();
		t_freeze();
		t_power();
		results();
	end
endmodule
